/* File: verilog/pi_controller_defs.vh */
// Behaviour
// - Mode input high selects automatic operation, low selects manual operation.
// - Output reset input forces output to zero and overrides the mode input.
// - Manual mode drives the output with the manual output value.
// - Entering automatic mode preloads the integral sum with the manual value.
// - Corrected process value is raw value times input gain plus input offset.
// - Corrected process value is clamped between the lower and upper limits.
// - Zero error leaves the manipulated output unchanged.
// - Positive direction: value above setpoint lowers output, below raises it.
// - Negative direction: value above setpoint raises output, below lowers it.
// - Proportional gain of zero drops the proportional term.
// - Integral time at its maximum setting drops the integral term.
// - Output is recomputed once per fixed 500 ms sample.
// - Manual output values outside 0 to 1000 are not accepted.
// - Limit settings outside -10000 to +20000 are not accepted.
// - Setpoint and manual value may come from another block's live result.
`ifndef PI_CONTROLLER_DEFS_VH
`define PI_CONTROLLER_DEFS_VH

////////////////////////////////////////////////////////////////////////////////
// Register indices
`define REG_CTRL          4'h0
`define REG_SETPOINT      4'h1
`define REG_PROP_GAIN     4'h2
`define REG_INTEG_TIME    4'h3
`define REG_MANUAL_OUT    4'h4
`define REG_PV_MIN        4'h5
`define REG_PV_MAX        4'h6
`define REG_IN_GAIN       4'h7
`define REG_IN_OFFSET     4'h8
`define REG_OUTPUT        4'h9
`define REG_CORR_PV       4'ha
`define REG_STATUS        4'hb

// Control register fields
`define CTRL_DIR_BIT      0
`define CTRL_SP_LINK_BIT  1
`define CTRL_MQ_LINK_BIT  2

// Status register fields
`define STAT_AUTO_BIT     0
`define STAT_RESET_BIT    1
`define STAT_BUSY_BIT     2

////////////////////////////////////////////////////////////////////////////////
// Reset values
`define RST_DIR           1'b1
`define RST_SETPOINT      16'sh0000
`define RST_PROP_GAIN     14'h0064
`define RST_INTEG_TIME    13'h003c
`define RST_MANUAL_OUT    16'sh0000
`define RST_PV_MIN        16'shd8f0
`define RST_PV_MAX        16'sh4e20
`define RST_IN_GAIN       16'sh0064
`define RST_IN_OFFSET     16'sh0000

////////////////////////////////////////////////////////////////////////////////
// Value ranges
`define LIM_LO            16'shd8f0
`define LIM_HI            16'sh4e20
`define MQ_LO             16'sh0000
`define MQ_HI             16'sh03e8
`define KC_MAX            14'h270f
`define TI_MIN            13'h0001
`define TI_MAX            13'h176f
`define GAIN_LO           16'shfc18
`define GAIN_HI           16'sh03e8
`define OFFS_LO           16'shd8f0
`define OFFS_HI           16'sh2710
`define OUT_MAX           10'h3e8
`define INTEG_MAX         48'sh0000_03e8_0000

// Fixed point: integral keeps 16 fraction bits; x/100 ~= x*5243 >> 19
`define INTEG_FRAC        16
`define HALF_SEC_SHIFT    15
`define DIV100_MUL        48'sh0000_0000_147b
`define DIV100_SHIFT      19

////////////////////////////////////////////////////////////////////////////////
// Timing
`define CLK_FREQ_HZ       40000000
`define SAMPLE_TIME_MS    500
`define SAMPLE_CYCLES     ((`CLK_FREQ_HZ / 1000) * `SAMPLE_TIME_MS)

`endif

/* File: verilog/pi_sample_tick.v */
`timescale 1ns/1ps
`include "pi_controller_defs.vh"

module pi_sample_tick
#(
    parameter CYCLES = `SAMPLE_CYCLES
)
(
    input  wire clk,
    input  wire rst,
    output reg  tick
);

    reg [31:0] count;

    // Free running so the sample grid does not depend on mode changes
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            count <= 32'h0000_0000;
            tick  <= 1'b0;
        end
        else if (count == CYCLES - 1)
        begin
            count <= 32'h0000_0000;
            tick  <= 1'b1;
        end
        else
        begin
            count <= count + 32'h0000_0001;
            tick  <= 1'b0;
        end
    end

endmodule

/* File: verilog/pi_process_controller.v */
`timescale 1ns/1ps
`include "pi_controller_defs.vh"

module pi_process_controller
#(
    parameter SAMPLE_CYCLES = `SAMPLE_CYCLES,
    parameter DIV_BITS      = 33
)
(
    input  wire               clk,
    input  wire               rst,
    input  wire        [3:0]  addr,
    input  wire        [15:0] wrData,
    input  wire               wrEn,
    input  wire               rdEn,
    output reg         [15:0] rdData,
    input  wire               autoMode,
    input  wire               outReset,
    input  wire signed [15:0] processValue,
    input  wire signed [15:0] setpointLink,
    input  wire signed [15:0] manualLink,
    output reg         [9:0]  manipulatedOutput
);

    localparam ST_IDLE  = 4'b0001;
    localparam ST_LOAD  = 4'b0010;
    localparam ST_DIV   = 4'b0100;
    localparam ST_APPLY = 4'b1000;

    ////////////////////////////////////////////////////////////////////////////
    // Functions

    function signed [47:0] ext48;
        input signed [15:0] v;
        begin
            ext48 = {{32{v[15]}}, v};
        end
    endfunction

    function inRange;
        input signed [15:0] v;
        input signed [15:0] lo;
        input signed [15:0] hi;
        begin
            inRange = (v >= lo) && (v <= hi);
        end
    endfunction

    function signed [15:0] clampTo;
        input signed [47:0] v;
        input signed [15:0] lo;
        input signed [15:0] hi;
        begin
            if (v > ext48(hi))
                clampTo = hi;
            else if (v < ext48(lo))
                clampTo = lo;
            else
                clampTo = v[15:0];
        end
    endfunction

    // Gains are held in hundredths; divide by 100 without a divider
    function signed [47:0] scale100;
        input signed [47:0] v;
        reg   signed [47:0] prod;
        begin
            prod     = v * `DIV100_MUL;
            scale100 = prod >>> `DIV100_SHIFT;
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Configuration

    reg                dirPositive;
    reg                spFromLink;
    reg                mqFromLink;
    reg signed [15:0]  setpointCfg;
    reg        [13:0]  propGain;
    reg        [12:0]  integralTime;
    reg signed [15:0]  manualCfg;
    reg signed [15:0]  pvMin;
    reg signed [15:0]  pvMax;
    reg signed [15:0]  inGain;
    reg signed [15:0]  inOffset;

    reg        [3:0]   state;
    reg                autoRun;
    reg signed [15:0]  corrPv;
    wire               tick;
    wire signed [15:0] wrSigned = wrData;

    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            dirPositive  <= `RST_DIR;
            spFromLink   <= 1'b0;
            mqFromLink   <= 1'b0;
            setpointCfg  <= `RST_SETPOINT;
            propGain     <= `RST_PROP_GAIN;
            integralTime <= `RST_INTEG_TIME;
            manualCfg    <= `RST_MANUAL_OUT;
            pvMin        <= `RST_PV_MIN;
            pvMax        <= `RST_PV_MAX;
            inGain       <= `RST_IN_GAIN;
            inOffset     <= `RST_IN_OFFSET;
        end
        else if (wrEn)
        begin
            case (addr)
                `REG_CTRL:
                begin
                    // Direction is frozen while automatic control runs
                    if (!autoRun)
                        dirPositive <= wrData[`CTRL_DIR_BIT];
                    spFromLink <= wrData[`CTRL_SP_LINK_BIT];
                    mqFromLink <= wrData[`CTRL_MQ_LINK_BIT];
                end
                `REG_SETPOINT:
                    if (inRange(wrSigned, `LIM_LO, `LIM_HI))
                        setpointCfg <= wrSigned;
                `REG_PROP_GAIN:
                    if (wrData[15:14] == 2'h0 && wrData[13:0] <= `KC_MAX)
                        propGain <= wrData[13:0];
                `REG_INTEG_TIME:
                    if (wrData[15:13] == 3'h0 && wrData[12:0] >= `TI_MIN && wrData[12:0] <= `TI_MAX)
                        integralTime <= wrData[12:0];
                `REG_MANUAL_OUT:
                    if (inRange(wrSigned, `MQ_LO, `MQ_HI))
                        manualCfg <= wrSigned;
                `REG_PV_MIN:
                    if (inRange(wrSigned, `LIM_LO, `LIM_HI))
                        pvMin <= wrSigned;
                `REG_PV_MAX:
                    if (inRange(wrSigned, `LIM_LO, `LIM_HI))
                        pvMax <= wrSigned;
                `REG_IN_GAIN:
                    if (inRange(wrSigned, `GAIN_LO, `GAIN_HI))
                        inGain <= wrSigned;
                `REG_IN_OFFSET:
                    if (inRange(wrSigned, `OFFS_LO, `OFFS_HI))
                        inOffset <= wrSigned;
                default:
                    ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Live operands

    // Linked manual value is clamped so the output range still holds
    wire signed [15:0] spEff = spFromLink ? setpointLink : setpointCfg;
    wire signed [15:0] mqEff = mqFromLink ? clampTo(ext48(manualLink), `MQ_LO, `MQ_HI) : manualCfg;

    wire signed [47:0] pvProduct = ext48(processValue) * ext48(inGain);
    wire signed [47:0] pvSum     = scale100(pvProduct) + ext48(inOffset);

    always @(posedge clk or posedge rst)
    begin
        if (rst)
            corrPv <= 16'sh0000;
        else
            corrPv <= clampTo(pvSum, pvMin, pvMax);
    end

    wire signed [47:0] errNow = dirPositive ? ext48(spEff) - ext48(corrPv)
                                            : ext48(corrPv) - ext48(spEff);

    ////////////////////////////////////////////////////////////////////////////
    // Sample sequencer with a restoring divider for error * Ts / Ti

    reg signed [47:0]         errLatch;
    reg signed [47:0]         pTerm;
    reg        [DIV_BITS-1:0] divNum;
    reg        [DIV_BITS-1:0] quot;
    reg        [13:0]         rem;
    reg        [5:0]          divCount;
    wire       [13:0]         trial    = {rem[12:0], divNum[DIV_BITS-1]};
    wire                      trialOk  = trial >= {1'b0, integralTime};
    wire                      runOk    = autoRun && autoMode && !outReset;
    wire signed [47:0]        errAbs   = errLatch[47] ? -errLatch : errLatch;
    wire signed [47:0]        gainProd = $signed({34'h0, propGain}) * errLatch;

    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            state    <= ST_IDLE;
            errLatch <= 48'sh0;
            pTerm    <= 48'sh0;
            divNum   <= {DIV_BITS{1'b0}};
            quot     <= {DIV_BITS{1'b0}};
            rem      <= 14'h0000;
            divCount <= 6'h00;
        end
        else if (!runOk)
        begin
            // A sample left over from before a mode change or reset is dropped
            state <= ST_IDLE;
        end
        else
        begin
            case (state)
                ST_IDLE:
                    if (tick && runOk)
                    begin
                        errLatch <= errNow;
                        state    <= ST_LOAD;
                    end
                ST_LOAD:
                begin
                    pTerm    <= (propGain == 14'h0) ? 48'sh0 : scale100(gainProd);
                    divNum   <= errAbs[DIV_BITS-1:0] << `HALF_SEC_SHIFT;
                    quot     <= {DIV_BITS{1'b0}};
                    rem      <= 14'h0000;
                    divCount <= DIV_BITS[5:0];
                    state    <= ST_DIV;
                end
                ST_DIV:
                begin
                    rem      <= trialOk ? trial - {1'b0, integralTime} : trial;
                    quot     <= {quot[DIV_BITS-2:0], trialOk};
                    divNum   <= {divNum[DIV_BITS-2:0], 1'b0};
                    divCount <= divCount - 6'h01;
                    if (divCount == 6'h01)
                        state <= ST_APPLY;
                end
                ST_APPLY:
                    state <= ST_IDLE;
                default:
                    state <= ST_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Integral sum and manipulated output

    reg signed [47:0] integ;
    reg signed [47:0] next_integ;
    reg signed [47:0] next_sum;
    wire              integOn = integralTime != `TI_MAX;
    wire signed [47:0] quotExt = {{(48-DIV_BITS){1'b0}}, quot};

    always @*
    begin
        next_integ = errLatch[47] ? integ - quotExt : integ + quotExt;
        // Anti-windup: the integral never leaves the output range
        if (next_integ < 48'sh0)
            next_integ = 48'sh0;
        else if (next_integ > `INTEG_MAX)
            next_integ = `INTEG_MAX;
        next_sum = pTerm + (integOn ? (next_integ >>> `INTEG_FRAC) : 48'sh0);
    end

    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            integ             <= 48'sh0;
            autoRun           <= 1'b0;
            manipulatedOutput <= 10'h000;
        end
        else if (outReset)
        begin
            // Taking the mode here means release never looks like an entry
            integ             <= 48'sh0;
            autoRun           <= autoMode;
            manipulatedOutput <= 10'h000;
        end
        else if (!autoMode)
        begin
            autoRun           <= 1'b0;
            manipulatedOutput <= mqEff[9:0];
        end
        else if (!autoRun)
        begin
            autoRun <= 1'b1;
            integ   <= ext48(mqEff) <<< `INTEG_FRAC;
        end
        else if (state == ST_APPLY && errLatch != 48'sh0)
        begin
            if (integOn)
                integ <= next_integ;
            if (next_sum < 48'sh0)
                manipulatedOutput <= 10'h000;
            else if (next_sum > {38'h0, `OUT_MAX})
                manipulatedOutput <= `OUT_MAX;
            else
                manipulatedOutput <= next_sum[9:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register read port

    always @(posedge clk or posedge rst)
    begin
        if (rst)
            rdData <= 16'h0000;
        else if (!rdEn)
            rdData <= 16'h0000;
        else
        begin
            case (addr)
                `REG_CTRL:       rdData <= {13'h0, mqFromLink, spFromLink, dirPositive};
                `REG_SETPOINT:   rdData <= setpointCfg;
                `REG_PROP_GAIN:  rdData <= {2'h0, propGain};
                `REG_INTEG_TIME: rdData <= {3'h0, integralTime};
                `REG_MANUAL_OUT: rdData <= manualCfg;
                `REG_PV_MIN:     rdData <= pvMin;
                `REG_PV_MAX:     rdData <= pvMax;
                `REG_IN_GAIN:    rdData <= inGain;
                `REG_IN_OFFSET:  rdData <= inOffset;
                `REG_OUTPUT:     rdData <= {6'h00, manipulatedOutput};
                `REG_CORR_PV:    rdData <= corrPv;
                `REG_STATUS:     rdData <= {13'h0, state != ST_IDLE, outReset, runOk};
                default:         rdData <= 16'h0000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sample clock enable

    pi_sample_tick
    #(
        .CYCLES (SAMPLE_CYCLES)
    )
    u_tick
    (
        .clk  (clk),
        .rst  (rst),
        .tick (tick)
    );

endmodule

/* File: tb/pi_controller_asserts.sv */
`timescale 1ns/1ps
module pi_controller_asserts
#(
    parameter SAMPLE_CYCLES = 60
)
(
    input wire               clk,
    input wire               rst,
    input wire        [3:0]  addr,
    input wire        [15:0] wrData,
    input wire               wrEn,
    input wire               rdEn,
    input wire        [15:0] rdData,
    input wire               autoMode,
    input wire               outReset,
    input wire signed [15:0] processValue,
    input wire signed [15:0] setpointLink,
    input wire signed [15:0] manualLink,
    input wire        [9:0]  manipulatedOutput
);
localparam int GAP_MIN = SAMPLE_CYCLES - 2;
reg        mqLink;
reg [9:0]  mqVal;
reg [9:0]  prevOut;
reg [15:0] prevLink;
reg [31:0] gap;
reg [31:0] steady;
wire       chg     = manipulatedOutput != prevOut;
wire       quiet   = !autoMode && !outReset && !wrEn && manualLink == prevLink;
wire [9:0] linkVal = manualLink < 0 ? 10'h000 : manualLink > 16'sh03e8 ? 10'h3e8 : manualLink[9:0];
wire [9:0] manExp  = mqLink ? linkVal : mqVal;
////////////////////////////////////////////////////////////////////////////////
// Shadow of the manual source, and spacing of output changes while in auto
always @(posedge clk or posedge rst)
begin
    if (rst)
    begin
        mqLink   <= 1'b0;
        mqVal    <= 10'h000;
        prevOut  <= 10'h000;
        prevLink <= 16'h0000;
        gap      <= 32'h0;
        steady   <= 32'h0;
    end
    else
    begin
        if (wrEn && addr == 4'h0)
            mqLink <= wrData[2];
        if (wrEn && addr == 4'h4 && !wrData[15] && wrData <= 16'h03e8)
            mqVal <= wrData[9:0];
        prevOut  <= manipulatedOutput;
        prevLink <= manualLink;
        gap      <= chg ? 32'h0 : gap + 32'h1;
        steady   <= (autoMode && !outReset) ? steady + 32'h1 : 32'h0;
    end
end
default clocking cb @(posedge clk);
endclocking
default disable iff (rst);
sequence releaseInAuto;
    outReset ##1 (!outReset && autoMode);
endsequence
sequence enterAuto;
    !autoMode ##1 (autoMode && !outReset);
endsequence
AST_RESET_ZERO: assert property (outReset |=> manipulatedOutput == 10'h000)
    else $error("output not zero under output reset");
AST_OUT_RANGE: assert property (manipulatedOutput <= 10'h3e8)
    else $error("output above full scale");
AST_MANUAL_SHOWS: assert property (quiet [*3] |-> manipulatedOutput == manExp)
    else $error("manual output differs from manual value");
AST_ENTRY_HOLD: assert property (enterAuto ##1 (autoMode && !outReset) [*7] |-> manipulatedOutput == $past(manipulatedOutput, 7))
    else $error("output moved right after auto entry");
AST_RESUME_ZERO: assert property (releaseInAuto ##1 (autoMode && !outReset) [*3] |-> manipulatedOutput == 10'h000)
    else $error("output not zero after reset release");
AST_SAMPLE_GAP: assert property (chg && steady > gap + 32'h2 |-> gap >= GAP_MIN)
    else $error("auto output changed faster than the sample period");
AST_READ_OUTPUT: assert property (rdEn && addr == 4'h9 |=> rdData == {6'h00, $past(manipulatedOutput)})
    else $error("output readback wrong");
AST_READ_IDLE: assert property (!rdEn |=> rdData == 16'h0000)
    else $error("read data not idle");
endmodule
bind pi_process_controller pi_controller_asserts #(.SAMPLE_CYCLES(SAMPLE_CYCLES)) chk (
    .clk(clk), .rst(rst), .addr(addr), .wrData(wrData), .wrEn(wrEn), .rdEn(rdEn), .rdData(rdData),
    .autoMode(autoMode), .outReset(outReset), .processValue(processValue), .setpointLink(setpointLink),
    .manualLink(manualLink), .manipulatedOutput(manipulatedOutput));

/* File: tb/upstream_source.sv */
`timescale 1ns/1ps
module upstream_source
(
    input  wire               clk,
    input  wire               rst,
    input  wire               slow,
    input  wire signed [15:0] pvSet,
    input  wire signed [15:0] spSet,
    input  wire signed [15:0] mqSet,
    output reg  signed [15:0] processValue,
    output reg  signed [15:0] setpointLink,
    output reg  signed [15:0] manualLink
);
reg [1:0] phase;
////////////////////////////////////////////////////////////////////////////////
// A slow source refreshes every fourth cycle, like a block on a longer scan
always @(posedge clk or posedge rst)
begin
    if (rst)
    begin
        phase        <= 2'h0;
        processValue <= 16'sh0000;
        setpointLink <= 16'sh0000;
        manualLink   <= 16'sh0000;
    end
    else
    begin
        phase <= phase + 2'h1;
        if (!slow || phase == 2'h0)
        begin
            processValue <= pvSet;
            setpointLink <= spSet;
            manualLink   <= mqSet;
        end
    end
end
endmodule

/* File: tb/pi_process_controller_test.sv */
`timescale 1ns/1ps
module pi_process_controller_test;
localparam SC = 60;
localparam [143:0] DFLT = {16'h0000, 16'h0064, 16'h4e20, 16'hd8f0, 16'h0000, 16'h003c, 16'h0064, 16'h0000, 16'h0001};
localparam logic [35:0] RNG [0:9] = '{36'h4_03e8_03e8, 36'h4_03e9_03e8, 36'h4_ffff_03e8, 36'h5_d8ef_d8f0,
    36'h6_4e21_4e20, 36'h1_4e20_4e20, 36'h1_d8ef_4e20, 36'h1_01f4_01f4, 36'h2_2710_0064, 36'h3_1770_003c};
reg                clk = 1'b0;
reg                rst = 1'b1;
reg         [3:0]  addr = 4'h0;
reg         [15:0] wrData = 16'h0000;
reg                wrEn = 1'b0;
reg                rdEn = 1'b0;
reg                autoMode = 1'b0;
reg                outReset = 1'b0;
reg                slow = 1'b0;
reg  signed [15:0] pvSet = 16'sh0000;
reg  signed [15:0] mqSet = 16'sh0000;
wire        [15:0] rdData;
wire signed [15:0] processValue;
wire signed [15:0] setpointLink;
wire signed [15:0] manualLink;
wire        [9:0]  manipulatedOutput;
integer            err_count = 0;
integer            compares = 0;
integer            seed = 32'h13b8;
integer            i;
reg         [9:0]  base;
reg                rdPend = 1'b0;
reg         [15:0] expQ [$];
pi_process_controller #(.SAMPLE_CYCLES(SC)) dut (
    .clk(clk), .rst(rst), .addr(addr), .wrData(wrData), .wrEn(wrEn), .rdEn(rdEn), .rdData(rdData),
    .autoMode(autoMode), .outReset(outReset), .processValue(processValue), .setpointLink(setpointLink),
    .manualLink(manualLink), .manipulatedOutput(manipulatedOutput));
upstream_source src (
    .clk(clk), .rst(rst), .slow(slow), .pvSet(pvSet), .spSet(16'sh01f4), .mqSet(mqSet),
    .processValue(processValue), .setpointLink(setpointLink), .manualLink(manualLink));
////////////////////////////////////////////////////////////////////////////////
task check(input [15:0] seen, input [15:0] exp);
begin
    compares = compares + 1;
    if (seen !== exp)
    begin
        err_count = err_count + 1;
        $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
end
endtask
task steps(input integer n);
    repeat (n) @(posedge clk);
endtask
task outIs(input [9:0] e);
    check({6'h00, manipulatedOutput}, {6'h00, e});
endtask
// Strobes drop for one cycle between transfers so no signal is set twice at one edge
task wr(input [3:0] a, input [15:0] d);
begin
    addr <= a;
    wrData <= d;
    wrEn <= 1'b1;
    @(posedge clk);
    wrEn <= 1'b0;
    @(posedge clk);
end
endtask
task rd(input [3:0] a, input [15:0] e);
begin
    addr <= a;
    rdEn <= 1'b1;
    expQ.push_back(e);
    @(posedge clk);
    rdEn <= 1'b0;
    @(posedge clk);
end
endtask
task test_done;
begin
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
        $display("STATUS OK");
    else
        $display("STATUS NOT OK");
    $finish;
end
endtask
// Read data stand only in the cycle after the strobe, so they are taken there
always @(posedge clk)
begin
    rdPend <= rdEn;
    if (rdPend)
        check(rdData, expQ.pop_front());
end
initial
begin
    forever #12.5 clk = ~clk;
end
initial
begin
    repeat (20000) @(posedge clk);
    err_count = err_count + 1;
    $display("Error at %0t: watchdog expired", $time);
    test_done;
end
initial
begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    for (i = 0; i < 9; i = i + 1)
        rd(i[3:0], DFLT[i * 16 +: 16]);
    rd(4'hc, 16'h0000);
    for (i = 0; i < 10; i = i + 1)
    begin
        wr(RNG[i][35:32], RNG[i][31:16]);
        rd(RNG[i][35:32], RNG[i][15:0]);
    end
    steps(2);
    outIs(10'h3e8);
    for (i = 0; i < 6; i = i + 1)
    begin
        base = 10'($unsigned($random(seed)) % 1001);
        wr(4'h4, {6'h00, base});
        steps(2);
        outIs(base);
    end
    $display("test manual mode done");
    slow <= 1'b1;
    mqSet <= 16'sd700;
    wr(4'h0, 16'h0005);
    steps(8);
    outIs(10'd700);
    wr(4'h0, 16'h0001);
    slow <= 1'b0;
    outReset <= 1'b1;
    autoMode <= 1'b1;
    steps(4);
    outIs(10'd0);
    autoMode <= 1'b0;
    steps(2);
    outReset <= 1'b0;
    steps(3);
    outIs(base);
    $display("test link and reset done");
    // With the integral term omitted every automatic result is exact
    wr(4'h4, 16'h0064);
    wr(4'h3, 16'h176f);
    pvSet <= 16'sd300;
    steps(3);
    rd(4'ha, 16'h012c);
    autoMode <= 1'b1;
    steps(8);
    outIs(10'd100);
    steps(3 * SC);
    outIs(10'd200);
    pvSet <= 16'sd500;
    steps(3 * SC);
    outIs(10'd200);
    pvSet <= 16'sd700;
    steps(3 * SC);
    outIs(10'd0);
    wr(4'h6, 16'h0190);
    pvSet <= 16'sd900;
    steps(3 * SC);
    rd(4'ha, 16'h0190);
    rd(4'h9, 16'h0064);
    outReset <= 1'b1;
    steps(4);
    outIs(10'd0);
    rd(4'hb, 16'h0002);
    outReset <= 1'b0;
    steps(6);
    outIs(10'd0);
    steps(3 * SC);
    outIs(10'd100);
    $display("test automatic mode done");
    autoMode <= 1'b0;
    steps(2);
    wr(4'h6, 16'h4e20);
    wr(4'h4, 16'h01f4);
    wr(4'h1, 16'h0000);
    wr(4'h0, 16'h0002);
    pvSet <= 16'sd300;
    autoMode <= 1'b1;
    steps(3 * SC);
    outIs(10'd0);
    autoMode <= 1'b0;
    steps(2);
    wr(4'h0, 16'h0003);
    wr(4'h2, 16'h0000);
    wr(4'h3, 16'h003c);
    autoMode <= 1'b1;
    steps(3 * SC);
    check({15'h0000, manipulatedOutput > 10'd500 && manipulatedOutput < 10'd510}, 16'h0001);
    autoMode <= 1'b0;
    wr(4'h7, 16'h00c8);
    wr(4'h8, 16'hffce);
    pvSet <= 16'sd100;
    steps(3);
    rd(4'ha, 16'h0096);
    steps(1);
    $display("test direction and gains done");
    test_done;
end
endmodule
